// ### dcffc_pkg.sv
// Constants, level codes and reset values for the FIFO flush control block.
// Behaviour
// - Each side samples its own flush request.
// - A flush crosses into the other side.
// - Status flags are invalid while flushing.
// - Write flush invalidates write flags until complete.
// - Read routine starts on next read edge.
// - Write flush takes two read cycles.
// - Entry-left flag marks write flush done.
// - Write level updates on next write edge.
// - Read flush takes two write cycles.
// - Entry-left flag marks read flush done.
// - Read level updates on next read edge.
// - Clock phase may add one cycle.
// - Immediate clear hits both pointers, unfiltered.
// - Write level code reports free room.
// - Read level code reports occupancy.
// - Entry-left flag when exactly one used.
// - Immediate clear polarity is selectable.
package dcffc_pkg;

  // Write side room codes.
  localparam logic [3:0] DCFFC_WL_FULL = 4'h0;
  localparam logic [3:0] DCFFC_WL_EMPTY = 4'h1;
  localparam logic [3:0] DCFFC_WL_HALF = 4'h2;
  localparam logic [3:0] DCFFC_WL_QUARTER = 4'h3;
  localparam logic [3:0] DCFFC_WL_64 = 4'h4;
  localparam logic [3:0] DCFFC_WL_32 = 4'hA;
  localparam logic [3:0] DCFFC_WL_16 = 4'hB;
  localparam logic [3:0] DCFFC_WL_8 = 4'hC;
  localparam logic [3:0] DCFFC_WL_4 = 4'hD;
  localparam logic [3:0] DCFFC_WL_2 = 4'hE;
  localparam logic [3:0] DCFFC_WL_1 = 4'hF;

  // Read side fill codes.
  localparam logic [3:0] DCFFC_RL_EMPTY = 4'h0;
  localparam logic [3:0] DCFFC_RL_1 = 4'h1;
  localparam logic [3:0] DCFFC_RL_2 = 4'h2;
  localparam logic [3:0] DCFFC_RL_4 = 4'h3;
  localparam logic [3:0] DCFFC_RL_8 = 4'h4;
  localparam logic [3:0] DCFFC_RL_16 = 4'h5;
  localparam logic [3:0] DCFFC_RL_32 = 4'h6;
  localparam logic [3:0] DCFFC_RL_64 = 4'h8;
  localparam logic [3:0] DCFFC_RL_QUARTER = 4'hD;
  localparam logic [3:0] DCFFC_RL_HALF = 4'hE;
  localparam logic [3:0] DCFFC_RL_FULL = 4'hF;

  // Band thresholds in entries.
  localparam int DCFFC_BAND_64 = 64;
  localparam int DCFFC_BAND_32 = 32;
  localparam int DCFFC_BAND_16 = 16;
  localparam int DCFFC_BAND_8 = 8;
  localparam int DCFFC_BAND_4 = 4;
  localparam int DCFFC_BAND_2 = 2;

  // Default depth and synchroniser length.
  localparam int DCFFC_DEPTH = 512;
  localparam int DCFFC_SYNC_STAGES = 2;

  // Reset values of the status outputs.
  localparam logic [3:0] DCFFC_WL_RESET = DCFFC_WL_EMPTY;
  localparam logic [3:0] DCFFC_RL_RESET = DCFFC_RL_EMPTY;

  // Flush sequencer states.
  typedef enum logic [2:0] {
    DCFFC_IDLE,
    DCFFC_W_WAIT,
    DCFFC_W_RUN,
    DCFFC_W_DONE,
    DCFFC_R_WAIT,
    DCFFC_R_RUN,
    DCFFC_R_DONE
  } dcffc_state_type;

endpackage

// ### dcffc_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module dcffc_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous inputs and their synchronised copies.
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_next = d_i;
    stable_next = meta_reg;
    if (!rst_n_i) begin
      meta_next = '0;
      stable_next = '0;
    end
  end

  // Registers of both stages.
  always_ff @(posedge clk_i) begin
    meta_reg <= meta_next;
    stable_reg <= stable_next;
  end

  assign q_o = stable_reg;

endmodule
`default_nettype wire

// ### dcffc_top.sv
// Flush control and level status for a FIFO with separate write and read clocks.
`timescale 1ns/1ps
`default_nettype none
module dcffc_top import dcffc_pkg::*; #(
  parameter int DEPTH = DCFFC_DEPTH
) (
  // System clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Write side pins.
  input wire logic write_clock_i,
  input wire logic write_flush_i,
  input wire logic push_i,
  // Read side pins.
  input wire logic read_clock_i,
  input wire logic read_flush_i,
  input wire logic pop_i,
  // Immediate clear and its polarity select.
  input wire logic immediate_clear_i,
  input wire logic clear_invert_i,
  // Status outputs.
  output logic [3:0] write_level_code_o,
  output logic [3:0] read_level_code_o,
  output logic one_slot_free_flag_o,
  output logic one_entry_left_flag_o,
  output logic flush_busy_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // Room code from the free slot count.
  function automatic logic [3:0] room_code(input int room);
    logic [3:0] code;
    code = DCFFC_WL_1;
    if (room == 0) code = DCFFC_WL_FULL;
    else if (room == DEPTH) code = DCFFC_WL_EMPTY;
    else if (room > DEPTH / 2) code = DCFFC_WL_HALF;
    else if (room > DEPTH / 4) code = DCFFC_WL_QUARTER;
    else if (room >= DCFFC_BAND_64) code = DCFFC_WL_64;
    else if (room >= DCFFC_BAND_32) code = DCFFC_WL_32;
    else if (room >= DCFFC_BAND_16) code = DCFFC_WL_16;
    else if (room >= DCFFC_BAND_8) code = DCFFC_WL_8;
    else if (room >= DCFFC_BAND_4) code = DCFFC_WL_4;
    else if (room >= DCFFC_BAND_2) code = DCFFC_WL_2;
    return code;
  endfunction

  // Fill code from the occupied slot count.
  function automatic logic [3:0] fill_code(input int used);
    logic [3:0] code;
    code = DCFFC_RL_1;
    if (used == 0) code = DCFFC_RL_EMPTY;
    else if (used == DEPTH) code = DCFFC_RL_FULL;
    else if (used >= DEPTH / 2) code = DCFFC_RL_HALF;
    else if (used >= DEPTH / 4) code = DCFFC_RL_QUARTER;
    else if (used >= DCFFC_BAND_64) code = DCFFC_RL_64;
    else if (used >= DCFFC_BAND_32) code = DCFFC_RL_32;
    else if (used >= DCFFC_BAND_16) code = DCFFC_RL_16;
    else if (used >= DCFFC_BAND_8) code = DCFFC_RL_8;
    else if (used >= DCFFC_BAND_4) code = DCFFC_RL_4;
    else if (used >= DCFFC_BAND_2) code = DCFFC_RL_2;
    return code;
  endfunction

  logic [7:0] pins_sync;
  logic wclk_s;
  logic rclk_s;
  logic wflush_s;
  logic rflush_s;
  logic push_s;
  logic pop_s;
  logic clear_s;
  logic invert_s;

  // All pin inputs pass two flip-flops before use.
  dcffc_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i({write_clock_i, read_clock_i, write_flush_i, read_flush_i,
          push_i, pop_i, immediate_clear_i, clear_invert_i}),
    .q_o(pins_sync)
  );

  assign {wclk_s, rclk_s, wflush_s, rflush_s, push_s, pop_s, clear_s, invert_s} = pins_sync;

  dcffc_state_type state_reg;
  dcffc_state_type state_next;
  logic wclk_prev_reg;
  logic wclk_prev_next;
  logic rclk_prev_reg;
  logic rclk_prev_next;
  logic [CW-1:0] wr_ptr_reg;
  logic [CW-1:0] wr_ptr_next;
  logic [CW-1:0] rd_ptr_reg;
  logic [CW-1:0] rd_ptr_next;
  logic [3:0] wlevel_reg;
  logic [3:0] wlevel_next;
  logic [3:0] rlevel_reg;
  logic [3:0] rlevel_next;
  logic slot_free_reg;
  logic slot_free_next;
  logic entry_left_reg;
  logic entry_left_next;
  logic busy_reg;
  logic busy_next;

  logic wedge;
  logic redge;
  logic clear_act;
  logic [CW-1:0] used;
  logic [CW-1:0] used_after;
  logic full;
  logic empty;

  // Rising edges of each side's clock, seen on the system clock.
  assign wedge = wclk_s & ~wclk_prev_reg;
  assign redge = rclk_s & ~rclk_prev_reg;
  assign clear_act = clear_s ^ invert_s;
  assign used = wr_ptr_reg - rd_ptr_reg;
  assign full = (int'(used) == DEPTH);
  assign empty = (used == '0);

  // Flush sequencer, pointers and status next values.
  always_comb begin
    state_next = state_reg;
    wclk_prev_next = wclk_s;
    rclk_prev_next = rclk_s;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    wlevel_next = wlevel_reg;
    rlevel_next = rlevel_reg;
    slot_free_next = slot_free_reg;
    entry_left_next = entry_left_reg;
    busy_next = busy_reg;
    used_after = used;
    case (state_reg)
      DCFFC_IDLE: begin
        if (wedge && wflush_s) begin
          state_next = DCFFC_W_WAIT;
          busy_next = 1'b1;
        end else if (redge && rflush_s) begin
          state_next = DCFFC_R_WAIT;
          busy_next = 1'b1;
        end else begin
          if (wedge && push_s && !full) wr_ptr_next = wr_ptr_reg + 1'b1;
          if (redge && pop_s && !empty) rd_ptr_next = rd_ptr_reg + 1'b1;
          used_after = wr_ptr_next - rd_ptr_next;
          if (wedge) begin
            wlevel_next = room_code(DEPTH - int'(used_after));
            slot_free_next = (DEPTH - int'(used_after)) == 1;
          end
          if (redge) begin
            rlevel_next = fill_code(int'(used_after));
            entry_left_next = (used_after == CW'(1));
          end
        end
      end
      // Write flush: the read side begins on its next edge.
      DCFFC_W_WAIT: if (redge) state_next = DCFFC_W_RUN;
      DCFFC_W_RUN: begin
        if (redge) begin
          state_next = DCFFC_W_DONE;
          wr_ptr_next = '0;
          rd_ptr_next = '0;
          rlevel_next = DCFFC_RL_EMPTY;
          entry_left_next = 1'b1;
        end
      end
      DCFFC_W_DONE: begin
        if (wedge) begin
          state_next = DCFFC_IDLE;
          wlevel_next = DCFFC_WL_EMPTY;
          slot_free_next = 1'b0;
          entry_left_next = 1'b0;
          busy_next = 1'b0;
        end
      end
      // Read flush: the write side runs two cycles of its own.
      DCFFC_R_WAIT: if (wedge) state_next = DCFFC_R_RUN;
      DCFFC_R_RUN: begin
        if (wedge) begin
          state_next = DCFFC_R_DONE;
          wr_ptr_next = '0;
          rd_ptr_next = '0;
          wlevel_next = DCFFC_WL_EMPTY;
          slot_free_next = 1'b0;
          entry_left_next = 1'b1;
        end
      end
      DCFFC_R_DONE: begin
        if (redge) begin
          state_next = DCFFC_IDLE;
          rlevel_next = DCFFC_RL_EMPTY;
          entry_left_next = 1'b0;
          busy_next = 1'b0;
        end
      end
      default: state_next = DCFFC_IDLE;
    endcase
    // The immediate clear overrides everything but reset, with no filtering.
    if (clear_act) begin
      state_next = DCFFC_IDLE;
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      wlevel_next = DCFFC_WL_EMPTY;
      rlevel_next = DCFFC_RL_EMPTY;
      slot_free_next = 1'b0;
      entry_left_next = 1'b0;
      busy_next = 1'b0;
    end
    if (!rst_n_i) begin
      state_next = DCFFC_IDLE;
      wclk_prev_next = 1'b0;
      rclk_prev_next = 1'b0;
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      wlevel_next = DCFFC_WL_RESET;
      rlevel_next = DCFFC_RL_RESET;
      slot_free_next = 1'b0;
      entry_left_next = 1'b0;
      busy_next = 1'b0;
    end
  end

  // State registers.
  always_ff @(posedge clock_i) begin
    state_reg <= state_next;
    wclk_prev_reg <= wclk_prev_next;
    rclk_prev_reg <= rclk_prev_next;
    wr_ptr_reg <= wr_ptr_next;
    rd_ptr_reg <= rd_ptr_next;
    wlevel_reg <= wlevel_next;
    rlevel_reg <= rlevel_next;
    slot_free_reg <= slot_free_next;
    entry_left_reg <= entry_left_next;
    busy_reg <= busy_next;
  end

  // Outputs come straight from registers.
  assign write_level_code_o = wlevel_reg;
  assign read_level_code_o = rlevel_reg;
  assign one_slot_free_flag_o = slot_free_reg;
  assign one_entry_left_flag_o = entry_left_reg;
  assign flush_busy_o = busy_reg;

endmodule
`default_nettype wire

// ### dcffc_top_assertions.sv
// Port assertions for the FIFO flush control block.
`timescale 1ns/1ps
`default_nettype none
module dcffc_checker (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Pins.
  input wire logic write_clock_i,
  input wire logic write_flush_i,
  input wire logic immediate_clear_i,
  input wire logic clear_invert_i,
  // Status.
  input wire logic [3:0] write_level_code_o,
  input wire logic [3:0] read_level_code_o,
  input wire logic one_slot_free_flag_o,
  input wire logic one_entry_left_flag_o,
  input wire logic flush_busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Reset leaves the levels empty and no flush running.
  a_reset_empty: assert property ($rose(rst_n_i) |-> write_level_code_o == 4'h1 &&
    read_level_code_o == 4'h0 && !flush_busy_o) else $error("reset levels wrong");
  // Reserved room and fill codes never show.
  a_room_legal: assert property (!(write_level_code_o inside {[4'h5:4'h9]}))
    else $error("reserved room code");
  a_fill_legal: assert property (!(read_level_code_o inside {4'h7, [4'h9:4'hC]}))
    else $error("reserved fill code");
  // A flush taken at a write edge makes the status invalid within a bound.
  a_write_flush_start: assert property ($rose(write_clock_i) && write_flush_i &&
    !flush_busy_o && immediate_clear_i == clear_invert_i |-> ##[2:6] flush_busy_o)
    else $error("write flush not taken");
  // A flush always ends.
  a_flush_ends: assert property ($rose(flush_busy_o) |-> ##[1:150] !flush_busy_o)
    else $error("flush never ended");
  // Completion leaves both sides empty.
  a_done_empty: assert property ($fell(flush_busy_o) |-> write_level_code_o == 4'h1 &&
    read_level_code_o == 4'h0 && !one_entry_left_flag_o) else $error("flush left data");
  // Single-slot flags agree with their level codes.
  a_left_code: assert property (one_entry_left_flag_o && !flush_busy_o |->
    read_level_code_o == 4'h1) else $error("entry flag without one entry");
  a_free_code: assert property (one_slot_free_flag_o && !flush_busy_o |->
    write_level_code_o == 4'hF) else $error("slot flag without one slot");
  // The done marker rises once the far side shows its cleared code.
  // A write flush clears the fill code first, a read flush the room code first.
  a_done_marker: assert property (flush_busy_o && $rose(one_entry_left_flag_o) |->
    read_level_code_o == 4'h0 || write_level_code_o == 4'h1) else $error("done marker early");
  // A held immediate clear empties both pointers and cancels a flush.
  a_clear_empty: assert property ((immediate_clear_i != clear_invert_i)[*5] |->
    write_level_code_o == 4'h1 && read_level_code_o == 4'h0 && !flush_busy_o)
    else $error("clear did not empty");
endmodule
bind dcffc_top dcffc_checker u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .write_clock_i(write_clock_i), .write_flush_i(write_flush_i),
  .immediate_clear_i(immediate_clear_i), .clear_invert_i(clear_invert_i),
  .write_level_code_o(write_level_code_o), .read_level_code_o(read_level_code_o),
  .one_slot_free_flag_o(one_slot_free_flag_o),
  .one_entry_left_flag_o(one_entry_left_flag_o), .flush_busy_o(flush_busy_o));
`default_nettype wire

// ### dcffc_fabric.sv
// Model of the user fabric that clocks and drives both FIFO ports.
`timescale 1ns/1ps
`default_nettype none
module dcffc_fabric (
  // System clock.
  input wire logic clock_i,
  // Port clocks and requests.
  output logic wclk_o,
  output logic wflush_o,
  output logic push_o,
  output logic rclk_o,
  output logic rflush_o,
  output logic pop_o
);
  int wcnt = 0;
  int rcnt = 0;
  initial begin
    {wclk_o, wflush_o, push_o, rclk_o, rflush_o, pop_o} = 6'h00;
  end
  // Port clocks run free at 80 ns and 100 ns, far below the sampling rate.
  always @(posedge clock_i) begin
    wcnt <= (wcnt == 3) ? 0 : wcnt + 1;
    rcnt <= (rcnt == 4) ? 0 : rcnt + 1;
    if (wcnt == 3) wclk_o <= #1 ~wclk_o;
    if (rcnt == 4) rclk_o <= #1 ~rclk_o;
  end
  // Holds a write request level from one falling edge across n rising edges.
  task automatic push_req(input bit flush, input int n);
    @(negedge wclk_o);
    push_o = !flush;
    wflush_o = flush;
    repeat (n) @(negedge wclk_o);
    push_o = 1'b0;
    wflush_o = 1'b0;
  endtask
  // Holds a read request level the same way on the read clock.
  task automatic pop_req(input bit flush, input int n);
    @(negedge rclk_o);
    pop_o = !flush;
    rflush_o = flush;
    repeat (n) @(negedge rclk_o);
    pop_o = 1'b0;
    rflush_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dcffc_top_bench.sv
// Self-checking bench for the FIFO flush control block.
`timescale 1ns/1ps
`default_nettype none
module dcffc_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clr = 1'b0;
  logic inv = 1'b0;
  logic wclk, wfl, push, rclk, rfl, pop, busy, free_f, left_f;
  logic [3:0] wlev, rlev;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  dcffc_top #(.DEPTH(16)) u_dut (.clock_i(clk), .rst_n_i(rst_n), .write_clock_i(wclk),
    .write_flush_i(wfl), .push_i(push), .read_clock_i(rclk), .read_flush_i(rfl),
    .pop_i(pop), .immediate_clear_i(clr), .clear_invert_i(inv), .write_level_code_o(wlev),
    .read_level_code_o(rlev), .one_slot_free_flag_o(free_f),
    .one_entry_left_flag_o(left_f), .flush_busy_o(busy));
  dcffc_fabric u_fab (.clock_i(clk), .wclk_o(wclk), .wflush_o(wfl), .push_o(push),
    .rclk_o(rclk), .rflush_o(rfl), .pop_o(pop));
  // Clock of 10 ns, and a cycle limit that cuts a hang short.
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Checks both codes and both single-slot flags.
  task automatic levels(input logic [3:0] w, input logic [3:0] r, input logic f, input logic e);
    check(wlev, w);
    check(rlev, r);
    check({3'h0, free_f}, {3'h0, f});
    check({3'h0, left_f}, {3'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Waits a bounded time for the busy flag to reach a level.
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 300) begin
      tick(1);
      n++;
    end
    check({3'h0, busy}, {3'h0, lvl});
  endtask
  // Waits a bounded time for the done marker, which must rise while busy.
  task automatic wait_left;
    int n;
    n = 0;
    while (left_f !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    check({3'h0, left_f}, 4'h1);
    check({3'h0, busy}, 4'h1);
  endtask
  task automatic do_reset(input logic pol);
    rst_n = 1'b0;
    inv = pol;
    clr = pol;
    tick(20);
    rst_n = 1'b1;
    tick(3);
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence; the done marker is read while busy, the other flags only once busy has dropped.
  initial begin
    do_reset(1'b0);
    levels(4'h1, 4'h0, 1'b0, 1'b0);
    u_fab.push_req(1'b0, 3);
    tick(80);
    levels(4'h2, 4'h2, 1'b0, 1'b0);
    u_fab.push_req(1'b1, 1);
    wait_busy(1'b1);
    check(rlev, 4'h2);
    wait_left();
    check(rlev, 4'h0);
    check(wlev, 4'h2);
    wait_busy(1'b0);
    levels(4'h1, 4'h0, 1'b0, 1'b0);
    $display("Test write flush done");
    u_fab.push_req(1'b0, 1);
    tick(80);
    levels(4'h2, 4'h1, 1'b0, 1'b1);
    u_fab.push_req(1'b0, 1);
    tick(40);
    levels(4'h2, 4'h2, 1'b0, 1'b0);
    u_fab.pop_req(1'b1, 1);
    wait_busy(1'b1);
    check(wlev, 4'h2);
    wait_left();
    check(wlev, 4'h1);
    check(rlev, 4'h2);
    wait_busy(1'b0);
    levels(4'h1, 4'h0, 1'b0, 1'b0);
    $display("Test read flush done");
    u_fab.push_req(1'b0, 15);
    tick(80);
    levels(4'hF, 4'hE, 1'b1, 1'b0);
    u_fab.push_req(1'b0, 2);
    tick(80);
    levels(4'h0, 4'hF, 1'b0, 1'b0);
    u_fab.pop_req(1'b0, 16);
    tick(80);
    levels(4'h1, 4'h0, 1'b0, 1'b0);
    $display("Test fill and drain done");
    u_fab.push_req(1'b0, 3);
    u_fab.push_req(1'b1, 1);
    wait_busy(1'b1);
    clr = 1'b1;
    wait_busy(1'b0);
    tick(8);
    clr = 1'b0;
    levels(4'h1, 4'h0, 1'b0, 1'b0);
    $display("Test clear in flush done");
    do_reset(1'b1);
    u_fab.push_req(1'b0, 2);
    tick(80);
    levels(4'h2, 4'h2, 1'b0, 1'b0);
    clr = 1'b0;
    tick(8);
    clr = 1'b1;
    levels(4'h1, 4'h0, 1'b0, 1'b0);
    $display("Test inverted clear done");
    complete_run();
  end
endmodule
`default_nettype wire
